// File: lsts_host_model.sv
// serial bus host model driving the sensor's two-wire port
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module lsts_host_model (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_rel
);
  // clk cycles per serial clock phase; the bench raises it to go slow
  int half = 4;

  // ----------------------------------------------------------------
  // bus conditions and single bits, all changed at falling clk edges
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_rel = 1'b1;
    wait_n(half);
    scl = 1'b1;
    wait_n(half);
    sda_rel = 1'b0;
    wait_n(half);
    scl = 1'b0;
    wait_n(1);
  endtask

  task automatic stop_cond();
    sda_rel = 1'b0;
    wait_n(half);
    scl = 1'b1;
    wait_n(half);
    sda_rel = 1'b1;
    wait_n(half);
  endtask

  // data settles one cycle after the clock falls, so no false start
  task automatic bit_xfer(input logic b, output logic r);
    sda_rel = b;
    wait_n(half);
    scl = 1'b1;
    wait_n(half);
    r = sda_in;
    scl = 1'b0;
    wait_n(1);
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(tx[i], r);
      rx[i] = r;
    end
    bit_xfer(ack_in, ack_out);
  endtask

  // ----------------------------------------------------------------
  // word transfers; nak bits are 1 where no acknowledge was seen
  // ----------------------------------------------------------------
  task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] nak);
    logic [7:0] rx;
    start_cond();
    byte_xfer({addr, 1'b0}, 1'b1, rx, nak[3]);
    byte_xfer(cmd, 1'b1, rx, nak[2]);
    byte_xfer(d[7:0], 1'b1, rx, nak[1]); // low byte first
    byte_xfer(d[15:8], 1'b1, rx, nak[0]);
    stop_cond();
  endtask

  task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd,
                           output logic [15:0] d, output logic [2:0] nak);
    logic [7:0] rx;
    logic a;
    start_cond();
    byte_xfer({addr, 1'b0}, 1'b1, rx, nak[2]);
    byte_xfer(cmd, 1'b1, rx, nak[1]);
    start_cond();
    byte_xfer({addr, 1'b1}, 1'b1, rx, nak[0]);
    byte_xfer(8'hFF, 1'b0, d[7:0], a); // ack low byte, nack high
    byte_xfer(8'hFF, 1'b1, d[15:8], a);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// File: lsts_pkg.sv
// constants shared by the light sensor register bank and its helpers
// assumes one 100 MHz clock and a synchronous active-low reset
package lsts_pkg;

  // ----------------------------------------------------------------
  // serial bus identity and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h10;
  localparam logic [7:0] CMD_CONFIG = 8'h00;
  localparam logic [7:0] CMD_UPPER = 8'h01;
  localparam logic [7:0] CMD_LOWER = 8'h02;
  localparam logic [7:0] CMD_SAVE = 8'h03;
  localparam logic [7:0] CMD_AMBIENT = 8'h04;
  localparam logic [7:0] CMD_WHITE = 8'h05;
  localparam logic [7:0] CMD_STATUS = 8'h06;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SD_BIT = 0;
  localparam int IRQ_BIT = 1;
  localparam int SAVE_EN_BIT = 0;
  localparam int SAVE_LO = 1;
  localparam int SAVE_HI = 2;
  localparam int BYTE_MSB = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [15:0] CONFIG_RST = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [2:0] SAVE_RST = 3'h0;
  localparam logic [12:0] SAVE_PAD = 13'h0000;
  localparam logic [13:0] STATUS_PAD = 14'h0000;

  // ----------------------------------------------------------------
  // serial slave states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_CMD = 9'h008,
    ST_CACK = 9'h010,
    ST_WDAT = 9'h020,
    ST_WACK = 9'h040,
    ST_RDAT = 9'h080,
    ST_RACK = 9'h100
  } lsts_state_type;

endpackage

// File: lsts_regs.sv
// serial slave and register bank of the ambient light sensor
// assumes scl_i and sda_i are already synchronous to clk and that
// the serial clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none
module lsts_regs
  import lsts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic meas_done,
  input wire logic [15:0] ambient_in,
  input wire logic [15:0] white_in,
  output logic [15:0] config_word,
  output logic shutdown,
  output logic threshold_irq_on,
  output logic saving_mode_on,
  output logic [1:0] saving_mode_select
);
  import lsts_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lsts_state_type state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic ack_on_r;
  logic rw_r;
  logic byte_hi_r;
  logic [7:0] cmd_r;
  logic [7:0] lo_r;
  logic [15:0] rd_word_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic [15:0] conf_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [2:0] save_r;
  logic [15:0] ambient_light;
  logic [15:0] white_light;
  logic sample_valid;
  logic below_bound_flag;
  logic above_bound_flag;

  // ----------------------------------------------------------------
  // bus condition decode
  // ----------------------------------------------------------------
  // start and stop are data edges while the clock stays high
  wire scl_rise = scl_i & ~scl_q_r;
  wire scl_fall = ~scl_i & scl_q_r;
  wire start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire stop = scl_i & scl_q_r & ~sda_q_r & sda_i;

  // byte assembly, msb first on the wire
  wire [7:0] rx_byte = {shift_r[6:0], sda_i};
  wire byte_end = scl_rise & (bit_cnt_r == LAST_BIT);
  wire addr_hit = (rx_byte[7:1] == DEV_ADDR);

  // state qualifiers
  wire st_addr = (state_r == ST_ADDR);
  wire st_wdat = (state_r == ST_WDAT);
  wire st_rack = (state_r == ST_RACK);

  // read byte: low half first, high half second
  wire [7:0] rd_byte = byte_hi_r ? rd_word_r[15:8] : rd_word_r[7:0];
  wire [2:0] rd_idx = LAST_BIT - bit_cnt_r;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // a word commits only on its high byte; extra byte pairs in the
  // same transfer simply rewrite the same register
  wire wr_commit = st_wdat & byte_end & byte_hi_r;
  wire [15:0] wr_word = {rx_byte, lo_r};
  wire we_conf = wr_commit & (cmd_r == CMD_CONFIG);
  wire we_upper = wr_commit & (cmd_r == CMD_UPPER);
  wire we_lower = wr_commit & (cmd_r == CMD_LOWER);
  wire we_save = wr_commit & (cmd_r == CMD_SAVE);
  // no write enable exists for the status word or the results

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  wire [15:0] status_word = {below_bound_flag, above_bound_flag,
                             STATUS_PAD};
  wire [15:0] save_word = {SAVE_PAD, save_r};
  wire [15:0] rd_src =
    (cmd_r == CMD_CONFIG) ? conf_r :
    (cmd_r == CMD_UPPER) ? upper_r :
    (cmd_r == CMD_LOWER) ? lower_r :
    (cmd_r == CMD_SAVE) ? save_word :
    (cmd_r == CMD_AMBIENT) ? ambient_light :
    (cmd_r == CMD_WHITE) ? white_light :
    (cmd_r == CMD_STATUS) ? status_word :
    WORD_ZERO;

  // the high status byte being acknowledged or refused clears both flags
  wire status_clr = st_rack & scl_rise & byte_hi_r
                    & (cmd_r == CMD_STATUS);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // previous levels for edge detection; the pins are already in the
  // clk domain, so no extra synchroniser stage is spent here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // ----------------------------------------------------------------
  // serial slave state machine
  // ----------------------------------------------------------------
  // ack phases: first falling edge pulls sda low, second releases it or, after a read address, drives the first data bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      ack_on_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rw_r <= 1'b0;
      byte_hi_r <= 1'b0;
      cmd_r <= 8'h00;
      rd_word_r <= WORD_ZERO;
    end else if (start) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 3'h0;
      ack_on_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_CMD, ST_WDAT: begin
          if (scl_rise) begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + BIT_ONE;
          end
          if (byte_end && st_addr) begin
            // foreign addresses are left alone until the next start
            state_r <= addr_hit ? ST_AACK : ST_IDLE;
            rw_r <= sda_i;
          end else if (byte_end && state_r == ST_CMD) begin
            cmd_r <= rx_byte;
            byte_hi_r <= 1'b0;
            state_r <= ST_CACK;
          end else if (byte_end) begin
            byte_hi_r <= ~byte_hi_r;
            state_r <= ST_WACK;
          end
        end
        ST_AACK, ST_CACK, ST_WACK: begin
          if (scl_fall && !ack_on_r) begin
            sda_oe_r <= 1'b1;
            ack_on_r <= 1'b1;
          end else if (scl_fall) begin
            ack_on_r <= 1'b0;
            sda_oe_r <= 1'b0;
            if (state_r != ST_AACK) begin
              state_r <= ST_WDAT;
            end else if (rw_r) begin
              // word frozen here so a new result cannot tear it
              rd_word_r <= rd_src;
              byte_hi_r <= 1'b0;
              sda_oe_r <= ~rd_src[BYTE_MSB];
              state_r <= ST_RDAT;
            end else begin
              state_r <= ST_CMD;
            end
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + BIT_ONE;
          end
          if (byte_end) begin
            state_r <= ST_RACK;
          end else if (scl_fall) begin
            sda_oe_r <= ~rd_byte[rd_idx];
          end
        end
        ST_RACK: begin
          if (scl_fall && !ack_on_r) begin
            sda_oe_r <= 1'b0;
          end else if (scl_fall) begin
            ack_on_r <= 1'b0;
            sda_oe_r <= ~rd_byte[BYTE_MSB];
            state_r <= ST_RDAT;
          end
          if (scl_rise && !sda_i) begin
            ack_on_r <= 1'b1;
            byte_hi_r <= ~byte_hi_r;
          end else if (scl_rise) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // low data byte parked until its high partner arrives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lo_r <= 8'h00;
    end else if (st_wdat && byte_end && !byte_hi_r) begin
      lo_r <= rx_byte;
    end
  end

  // open drain: the data level driven is always low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  // reserved power saving bits are not stored and read back as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conf_r <= CONFIG_RST;
      upper_r <= THRESH_RST;
      lower_r <= THRESH_RST;
      save_r <= SAVE_RST;
    end else begin
      if (we_conf) conf_r <= wr_word;
      if (we_upper) upper_r <= wr_word;
      if (we_lower) lower_r <= wr_word;
      if (we_save) save_r <= wr_word[SAVE_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // result hold and window detection
  // ----------------------------------------------------------------
  lsts_result_hold u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .meas_done(meas_done),
    .ambient_in(ambient_in),
    .white_in(white_in),
    .shutdown(conf_r[SD_BIT]),
    .ambient_light(ambient_light),
    .white_light(white_light),
    .sample_valid(sample_valid)
  );

  lsts_window_cmp u_cmp (
    .clk(clk),
    .rst_n(rst_n),
    .sample_valid(sample_valid),
    .sample(ambient_light),
    .upper(upper_r),
    .lower(lower_r),
    .irq_on(conf_r[IRQ_BIT]),
    .clr(status_clr),
    .below_bound_flag(below_bound_flag),
    .above_bound_flag(above_bound_flag)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the converter uses the mode select only while saving is on
  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;
  assign config_word = conf_r;
  assign shutdown = conf_r[SD_BIT];
  assign threshold_irq_on = conf_r[IRQ_BIT];
  assign saving_mode_on = save_r[SAVE_EN_BIT];
  assign saving_mode_select = save_r[SAVE_HI:SAVE_LO];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_write_upper: assert property (@(posedge clk) disable iff (!rst_n)
    we_upper |=> upper_r == $past(wr_word))
    else $error("upper threshold not written");
  a_write_lower: assert property (@(posedge clk) disable iff (!rst_n)
    we_lower |=> lower_r == $past(wr_word))
    else $error("lower threshold not written");
  a_save_field: assert property (@(posedge clk) disable iff (!rst_n)
    we_save |=> saving_mode_select == $past(wr_word[SAVE_HI:SAVE_LO]))
    else $error("saving mode select wrong");
  a_save_enable: assert property (@(posedge clk) disable iff (!rst_n)
    we_save |=> saving_mode_on == $past(wr_word[SAVE_EN_BIT]))
    else $error("saving enable wrong");
  a_foreign_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (st_addr && byte_end && !addr_hit) |=> state_r == ST_IDLE
      && !sda_oe_r)
    else $error("foreign address answered");
  a_read_lo_first: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_AACK && scl_fall && ack_on_r && rw_r)
      |=> !byte_hi_r && sda_oe_r == !rd_word_r[BYTE_MSB])
    else $error("read does not open with low byte");
  a_read_ambient: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_AACK && scl_fall && ack_on_r && rw_r
      && cmd_r == CMD_AMBIENT) |=> rd_word_r == $past(ambient_light))
    else $error("ambient read word wrong");
  a_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_commit && cmd_r == CMD_STATUS && !sample_valid)
      |=> !$rose(below_bound_flag) && !$rose(above_bound_flag))
    else $error("status flag set by write");

endmodule
`default_nettype wire

// File: lsts_result_hold.sv
// holds the latest ambient and white results from the converter
// assumes meas_done is a one-cycle pulse with both results valid
`timescale 1ns/1ps
`default_nettype none
module lsts_result_hold
  import lsts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_done,
  input wire logic [15:0] ambient_in,
  input wire logic [15:0] white_in,
  input wire logic shutdown,
  output logic [15:0] ambient_light,
  output logic [15:0] white_light,
  output logic sample_valid
);

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // conversions finishing during shutdown are dropped, so the last
  // values stay readable until the sensor is woken again
  wire take = meas_done & ~shutdown;

  // result registers and the fresh-sample pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ambient_light <= WORD_ZERO;
      white_light <= WORD_ZERO;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= take;
      if (take) begin
        ambient_light <= ambient_in;
        white_light <= white_in;
      end
    end
  end

  a_hold_shut: assert property (@(posedge clk) disable iff (!rst_n)
    shutdown |=> $stable(ambient_light) && $stable(white_light))
    else $error("result changed while shut down");
  a_fresh_take: assert property (@(posedge clk) disable iff (!rst_n)
    (meas_done && !shutdown) |=> sample_valid
      && ambient_light == $past(ambient_in))
    else $error("fresh result not taken");

endmodule
`default_nettype wire

// File: lsts_window_cmp.sv
// window comparator with the two sticky crossing flags
// assumes clr is a one-cycle pulse from the status read
`timescale 1ns/1ps
`default_nettype none
module lsts_window_cmp
  import lsts_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic irq_on,
  input wire logic clr,
  output logic below_bound_flag,
  output logic above_bound_flag
);

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  // thresholds only matter while detection is switched on
  wire check = sample_valid & irq_on;
  wire set_lo = check & (sample < lower);
  wire set_hi = check & (sample > upper);
  // set beats clear so a crossing in the same cycle as clr survives
  wire lo_nxt = set_lo | (below_bound_flag & ~clr);
  wire hi_nxt = set_hi | (above_bound_flag & ~clr);

  // sticky flags, cleared only by the status read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      below_bound_flag <= 1'b0;
      above_bound_flag <= 1'b0;
    end else begin
      below_bound_flag <= lo_nxt;
      above_bound_flag <= hi_nxt;
    end
  end

  a_low_set: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_valid && irq_on && sample < lower) |=> below_bound_flag)
    else $error("low crossing not flagged");
  a_high_set: assert property (@(posedge clk) disable iff (!rst_n)
    (sample_valid && irq_on && sample > upper) |=> above_bound_flag)
    else $error("high crossing not flagged");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !irq_on |=> !$rose(below_bound_flag) && !$rose(above_bound_flag))
    else $error("flag set while detection off");

endmodule
`default_nettype wire

// File: test_lsts_regs.sv
// self-checking bench for the sensor register bank and serial slave
// assumes lsts_host_model as bus host and the lsts_pkg constants
`timescale 1ns/1ps
`default_nettype none
module test_lsts_regs;
  import lsts_pkg::*;
  logic clk, rst_n, meas_done, scl, host_rel;
  logic sda_o, sda_oe, shutdown, threshold_irq_on, saving_mode_on;
  logic [1:0] saving_mode_select;
  logic [15:0] ambient_in, white_in, config_word;
  logic [15:0] lfsr_state = 16'h0039;
  int n_fail = 0;
  int compares = 0;
  // open-drain data line with pull-up: either party may pull it low
  wire logic sda_line = host_rel & ~(sda_oe & ~sda_o);

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  lsts_regs i_lsts_regs (.clk(clk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .meas_done(meas_done), .ambient_in(ambient_in),
    .white_in(white_in), .config_word(config_word),
    .shutdown(shutdown), .threshold_irq_on(threshold_irq_on),
    .saving_mode_on(saving_mode_on),
    .saving_mode_select(saving_mode_select));
  lsts_host_model i_lsts_host_model (.clk(clk), .sda_in(sda_line),
    .scl(scl), .sda_rel(host_rel));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13]
                  ^ lfsr_state[12] ^ lfsr_state[10]};
    return lfsr_state;
  endfunction

  // strict compares: a result equal to a bound raises nothing
  function automatic logic [15:0] exp_status(input logic [15:0] amb,
      input logic [15:0] lo, input logic [15:0] hi, input logic irq);
    return irq ? {amb < lo, amb > hi, 14'h0000} : 16'h0000;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic [3:0] nak;
    i_lsts_host_model.write_word(DEV_ADDR, cmd, d, nak);
    check({12'h000, nak}, WORD_ZERO);
  endtask

  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic [2:0] nak;
    i_lsts_host_model.read_word(DEV_ADDR, cmd, d, nak);
    check({13'h0000, nak}, WORD_ZERO);
  endtask

  // inputs flip after the pulse so stale values cannot pass for good
  task automatic measure(input logic [15:0] a, input logic [15:0] w);
    @(negedge clk);
    meas_done = 1'b1;
    ambient_in = a;
    white_in = w;
    @(negedge clk);
    meas_done = 1'b0;
    ambient_in = ~a;
    white_in = ~w;
    repeat (3) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // about a third of this span is needed by the sequence below
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    logic [15:0] d, lo, hi, amb, w;
    logic [3:0] nak;
    rst_n = 1'b0;
    meas_done = 1'b0;
    ambient_in = 16'h0000;
    white_in = 16'h0000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check(config_word, CONFIG_RST);
    check({10'h000, shutdown, threshold_irq_on, saving_mode_on,
           saving_mode_select, sda_oe}, 16'h0020);
    lo = rnd() & 16'h7FFF | 16'h0001;
    hi = rnd() & 16'hFFFE | 16'h8000;
    wr(CMD_UPPER, hi);
    wr(CMD_LOWER, lo);
    rd(CMD_UPPER, d);
    check(d, hi);
    rd(CMD_LOWER, d);
    check(d, lo);
    // a foreign address is neither acknowledged nor stored
    i_lsts_host_model.write_word(7'h11, CMD_UPPER, ~hi, nak);
    check({12'h000, nak}, 16'h000F);
    rd(CMD_UPPER, d);
    check(d, hi);
    for (int m = 0; m < 8; m++) begin
      wr(CMD_SAVE, {SAVE_PAD, m[2:0]});
      check({14'h0000, saving_mode_select}, {14'h0000, m[2:1]});
      check({15'h0000, saving_mode_on}, {15'h0000, m[0]});
    end
    // still shut down from reset: the result must not move
    measure(rnd(), rnd());
    rd(CMD_AMBIENT, d);
    check(d, WORD_ZERO);
    wr(CMD_CONFIG, 16'h0002);
    check({14'h0000, threshold_irq_on, shutdown}, 16'h0002);
    for (int k = 0; k < 12; k++) begin
      case (k)
        0, 10: amb = lo - 16'h0001;
        1: amb = lo;
        2: amb = hi;
        3, 11: amb = hi + 16'h0001;
        default: amb = rnd();
      endcase
      w = rnd();
      i_lsts_host_model.half = (k == 5) ? 12 : 4;
      if (k == 10) begin
        wr(CMD_CONFIG, 16'h0000);
      end
      measure(amb, w);
      rd(CMD_AMBIENT, d);
      check(d, amb);
      rd(CMD_WHITE, d);
      check(d, w);
      rd(CMD_STATUS, d);
      check(d, exp_status(amb, lo, hi, k < 10));
    end
    wr(CMD_STATUS, 16'hFFFF);
    rd(CMD_STATUS, d);
    check(d, WORD_ZERO);
    wr(CMD_CONFIG, CONFIG_RST);
    measure(rnd(), rnd());
    rd(CMD_AMBIENT, d);
    check(d, amb);
    print_verdict();
  end
endmodule
`default_nettype wire
